// ### logic/fcp_pkg.sv
// Constants, command codes and register map of the flash command host
package fcp_pkg;
	localparam int CLK_NS = 4;
	// Least bus timings, rounded up to whole clocks
	localparam int T_SETUP_NS = 10;
	localparam int T_WP_NS = 35;
	localparam int T_WPH_NS = 30;
	localparam int T_ACC_NS = 70;
	localparam int T_DF_NS = 20;
	localparam logic [7:0] T_SETUP_CYC = 8'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] T_WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] T_WPH_CYC = 8'((T_WPH_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] T_ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0] T_DF_CYC = 8'((T_DF_NS + CLK_NS - 1) / CLK_NS);
	// Longest gap between sector additions, rounded down
	localparam int ERASE_WIN_US = 50;
	localparam int ERASE_WIN_CYC = ERASE_WIN_US * 1000 / CLK_NS;

	localparam int FA_W = 17;
	localparam logic [16:0] UNLOCK1_ADDR = 17'h00555;
	localparam logic [16:0] UNLOCK2_ADDR = 17'h002aa;
	localparam logic [16:0] AS_MAKER_OFS = 17'h00000;
	localparam logic [16:0] AS_DEVICE_OFS = 17'h00001;
	localparam logic [16:0] AS_PROTECT_OFS = 17'h00002;
	localparam logic [7:0] D_UNLOCK1 = 8'haa;
	localparam logic [7:0] D_UNLOCK2 = 8'h55;
	localparam logic [7:0] D_RESET = 8'hf0;
	localparam logic [7:0] D_AUTOSEL = 8'h90;
	localparam logic [7:0] D_PROGRAM = 8'ha0;
	localparam logic [7:0] D_BYPASS = 8'h20;
	localparam logic [7:0] D_BYP_EXIT1 = 8'h90;
	localparam logic [7:0] D_BYP_EXIT2 = 8'h00;
	localparam logic [7:0] D_ERASE_SETUP = 8'h80;
	localparam logic [7:0] D_CHIP = 8'h10;
	localparam logic [7:0] D_SECTOR = 8'h30;
	localparam logic [7:0] D_SUSPEND = 8'hb0;
	localparam logic [7:0] D_RESUME = 8'h30;
	localparam int POLL_BIT = 7;
	localparam int FAIL_BIT = 5;

	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;
	localparam int CTRL_NOPOLL_BIT = 4;
	localparam int CTRL_GO_BIT = 8;
	localparam int CTRL_HWRST_BIT = 9;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;
	localparam int ST_REFUSED = 3;
	localparam int ST_BYPASS = 4;
	localparam int ST_SUSPENDED = 5;
	localparam int ST_AUTOSEL = 6;
	localparam int ST_WINDOW = 7;
	localparam int ST_ERASING = 8;
	localparam int ST_RDATA_LSB = 16;

	typedef enum logic [3:0] {
		CMD_READ, CMD_RESET, CMD_AUTOSEL, CMD_PROGRAM, CMD_BYP_ENTER, CMD_BYP_PROGRAM,
		CMD_BYP_EXIT, CMD_CHIP_ERASE, CMD_SECTOR_ERASE, CMD_SECTOR_ADD, CMD_SUSPEND,
		CMD_RESUME, CMD_POLL
	} fcp_cmd_e;

	typedef struct packed {
		logic last;
		logic rd;
		logic [16:0] addr;
		logic [7:0] data;
	} fcp_step_s;
endpackage : fcp_pkg

// ### logic/fcp_bus_cycle.sv
// One timed read or write cycle on the flash pins
module fcp_bus_cycle
	import fcp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic start,
	input wire logic rd,
	input wire logic [fcp_pkg::FA_W-1:0] addr,
	input wire logic [7:0] wdata,
	output logic done,
	output logic [7:0] rdata,
	output logic [fcp_pkg::FA_W-1:0] flash_addr,
	output logic [7:0] flash_dq_o,
	output logic flash_dq_oe_n,
	input wire logic [7:0] flash_dq_i,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n
);
	typedef enum logic [1:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD} fcp_eng_e;
	fcp_eng_e ph_q;
	logic rd_q;
	logic [7:0] cnt_q;
	wire cnt_end = (cnt_q == 8'h01);
	wire [7:0] pulse_cyc = rd_q ? T_ACC_CYC : T_WP_CYC;
	wire [7:0] hold_cyc = rd_q ? T_DF_CYC : T_WPH_CYC;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ph_q <= E_IDLE;
			rd_q <= 1'b0;
			cnt_q <= 8'h00;
			done <= 1'b0;
			rdata <= 8'h00;
			flash_addr <= '0;
			flash_dq_o <= 8'h00;
			flash_dq_oe_n <= 1'b1;
			flash_ce_n <= 1'b1;
			flash_oe_n <= 1'b1;
			flash_we_n <= 1'b1;
		end
		else
		begin
			done <= 1'b0;
			cnt_q <= cnt_q - 8'h01;
			case (ph_q)
				E_IDLE:
				begin
					cnt_q <= T_SETUP_CYC;
					if (start)
					begin
						// Address and data set up before the strobe falls
						ph_q <= E_SETUP;
						rd_q <= rd;
						flash_addr <= addr;
						flash_dq_o <= wdata;
						flash_dq_oe_n <= rd;
						flash_ce_n <= 1'b0;
					end
				end
				E_SETUP:
					if (cnt_end)
					begin
						ph_q <= E_PULSE;
						cnt_q <= pulse_cyc;
						flash_oe_n <= !rd_q;
						flash_we_n <= rd_q;
					end
				E_PULSE:
					if (cnt_end)
					begin
						// Device takes the data on this rising strobe
						ph_q <= E_HOLD;
						cnt_q <= hold_cyc;
						flash_oe_n <= 1'b1;
						flash_we_n <= 1'b1;
						if (rd_q)
							rdata <= flash_dq_i;
					end
				E_HOLD:
					if (cnt_end)
					begin
						ph_q <= E_IDLE;
						flash_ce_n <= 1'b1;
						flash_dq_oe_n <= 1'b1;
						done <= 1'b1;
					end
				default:
					ph_q <= E_IDLE;
			endcase
		end
	end
endmodule : fcp_bus_cycle

// ### logic/fcp_host.sv
// Flash command host: APB registers, command sequences and status polling
// Overview of operation
// - Reset command: one F0 write anywhere, leaves autoselect, clears failures.
// - Autoselect: AA/555, 55/2AA, 90/555, then a read at the offset.
// - Protect verify reads sector address with A1 high, A0 low.
// - Program: AA/555, 55/2AA, A0/555, then data at target.
// - Bypass entered by 20/555 third cycle; two-cycle program only then.
// - Bypass exit: 90 then 00, any address, back to array read.
// - Erase: six writes, chip ends 10/555, sector ends 30/sector.
// - Every command cycle is a write except data reads.
// - Plain array reads need no unlock or command cycles.
// - Poll at program address, or inside an erased sector.
// - After bit 7 turns true, take data on a following read.
//
// Our own choices: the APB slave port and the register addresses.
module fcp_host
	import fcp_pkg::*;
#(
	parameter int ERASE_WIN_CYCLES = fcp_pkg::ERASE_WIN_CYC
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [fcp_pkg::FA_W-1:0] flash_addr,
	output logic [7:0] flash_dq_o,
	output logic flash_dq_oe_n,
	input wire logic [7:0] flash_dq_i,
	output logic flash_ce_n,
	output logic flash_oe_n,
	output logic flash_we_n,
	output logic flash_reset_n
);
	import fcp_pkg::*;

	typedef enum logic [3:0] {
		S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_PWAIT, S_FINAL, S_FWAIT, S_ABORT, S_AWAIT
	} fcp_state_e;

	fcp_state_e state_q;
	fcp_cmd_e cmd_q;
	logic [2:0] idx_q;
	logic [16:0] addr_q;
	logic [7:0] wdata_q;
	logic [7:0] rdata_q;
	logic nopoll_q, exp_q, rechk_q;
	logic eng_start_q, eng_rd_q;
	logic [16:0] eng_addr_q;
	logic [7:0] eng_data_q;
	logic done_q, fail_q, refused_q, hwrst_q;
	logic bypass_q, suspended_q, autosel_q, erasing_q;
	logic [31:0] win_q;
	logic eng_done;
	logic [7:0] eng_rdata;

	// One cycle of a command sequence; unlock addresses carry zero upper bits
	function automatic fcp_step_s step_f(fcp_cmd_e c, logic [2:0] i, logic [16:0] a,
		logic [7:0] d);
		fcp_step_s s;
		s = '{last: 1'b0, rd: 1'b0, addr: UNLOCK1_ADDR, data: D_UNLOCK1};
		if (i == 3'd1 || i == 3'd4)
		begin
			s.addr = UNLOCK2_ADDR;
			s.data = D_UNLOCK2;
		end
		case (c)
			CMD_READ: s = '{last: 1'b1, rd: 1'b1, addr: a, data: d};
			CMD_RESET: s = '{last: 1'b1, rd: 1'b0, addr: a, data: D_RESET};
			// fourth cycle reads at the caller's offset
			CMD_AUTOSEL:
				if (i == 3'd2)
					s.data = D_AUTOSEL;
				else if (i == 3'd3)
					s = '{last: 1'b1, rd: 1'b1, addr: a, data: d};
			CMD_PROGRAM:
				if (i == 3'd2)
					s.data = D_PROGRAM;
				else if (i == 3'd3)
					s = '{last: 1'b1, rd: 1'b0, addr: a, data: d};
			CMD_BYP_ENTER:
				if (i == 3'd2)
					s = '{last: 1'b1, rd: 1'b0, addr: UNLOCK1_ADDR, data: D_BYPASS};
			CMD_BYP_PROGRAM: s = '{last: i[0], rd: 1'b0, addr: a, data: i[0] ? d : D_PROGRAM};
			CMD_BYP_EXIT:
				s = '{last: i[0], rd: 1'b0, addr: a, data: i[0] ? D_BYP_EXIT2 : D_BYP_EXIT1};
			CMD_CHIP_ERASE, CMD_SECTOR_ERASE:
				if (i == 3'd2)
					s.data = D_ERASE_SETUP;
				else if (i == 3'd5 && c == CMD_CHIP_ERASE)
					s = '{last: 1'b1, rd: 1'b0, addr: UNLOCK1_ADDR, data: D_CHIP};
				else if (i == 3'd5)
					s = '{last: 1'b1, rd: 1'b0, addr: a, data: D_SECTOR};
			CMD_SECTOR_ADD: s = '{last: 1'b1, rd: 1'b0, addr: a, data: D_SECTOR};
			CMD_SUSPEND: s = '{last: 1'b1, rd: 1'b0, addr: a, data: D_SUSPEND};
			CMD_RESUME: s = '{last: 1'b1, rd: 1'b0, addr: a, data: D_RESUME};
			default: s = '{last: 1'b1, rd: 1'b1, addr: a, data: d};
		endcase
		return s;
	endfunction : step_f

	wire fcp_step_s step = step_f(cmd_q, idx_q, addr_q, wdata_q);
	wire ctrl_sel = (paddr == REG_CTRL);
	wire apb_wr = psel && penable && pwrite && pready;
	wire go_wr = apb_wr && ctrl_sel && pwdata[CTRL_GO_BIT];
	wire fcp_cmd_e go_cmd = fcp_cmd_e'(pwdata[3:0]);
	wire win_open = (win_q != 32'h0);
	wire go_is_cmd = (pwdata[3:0] <= 4'(CMD_POLL));
	// bypass accepts only its own commands and reads
	wire deny_byp = bypass_q && !(go_cmd inside {CMD_BYP_PROGRAM, CMD_BYP_EXIT, CMD_READ});
	// erasing accepts suspend, additions, polls, reads and reset only
	wire deny_erase = erasing_q && !suspended_q
		&& !(go_cmd inside {CMD_SUSPEND, CMD_SECTOR_ADD, CMD_POLL, CMD_READ, CMD_RESET});
	// suspend allows read, program and autoselect
	wire deny_susp = suspended_q
		&& (go_cmd inside {CMD_CHIP_ERASE, CMD_SECTOR_ERASE, CMD_SECTOR_ADD, CMD_SUSPEND,
		CMD_BYP_ENTER});
	wire deny_mode = (go_cmd == CMD_BYP_PROGRAM && !bypass_q)
		|| (go_cmd == CMD_SUSPEND && !erasing_q)
		|| (go_cmd == CMD_RESUME && !suspended_q)
		|| (go_cmd == CMD_SECTOR_ADD && (!win_open || suspended_q));
	wire go_ok = go_is_cmd && !hwrst_q && (state_q == S_IDLE)
		&& !deny_byp && !deny_erase && !deny_susp && !deny_mode;
	wire poll_cmd = cmd_q inside {CMD_PROGRAM, CMD_BYP_PROGRAM, CMD_CHIP_ERASE,
		CMD_SECTOR_ERASE, CMD_SECTOR_ADD, CMD_SUSPEND};
	wire seq_end = (state_q == S_WAIT) && eng_done && step.last;
	wire poll_match = (eng_rdata[POLL_BIT] == exp_q);
	wire finish_ok = (seq_end && !(poll_cmd && !nopoll_q))
		|| ((state_q == S_FWAIT) && eng_done);
	wire finish_fail = (state_q == S_AWAIT) && eng_done;
	wire [31:0] status_w = {8'h00, rdata_q, 7'h00, erasing_q, win_open, autosel_q,
		suspended_q, bypass_q, refused_q, fail_q, done_q, (state_q != S_IDLE)};
	wire [31:0] rd_mux = (paddr == REG_STATUS) ? status_w
		: (paddr == REG_ADDR) ? {15'h0000, addr_q}
		: (paddr == REG_WDATA) ? {24'h000000, wdata_q}
		: ctrl_sel ? {22'h0, hwrst_q, 4'h0, nopoll_q, cmd_q} : 32'h0;
	wire mapped = ctrl_sel || paddr inside {REG_ADDR, REG_WDATA, REG_STATUS};

	// Zero-wait slave: answer prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable && !pwrite)
				prdata <= rd_mux;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			addr_q <= '0;
			wdata_q <= 8'h00;
			hwrst_q <= 1'b0;
			flash_reset_n <= 1'b0;
		end
		else
		begin
			flash_reset_n <= !hwrst_q;
			if (apb_wr && paddr == REG_ADDR && state_q == S_IDLE)
				addr_q <= pwdata[16:0];
			if (apb_wr && paddr == REG_WDATA && state_q == S_IDLE)
				wdata_q <= pwdata[7:0];
			if (apb_wr && ctrl_sel)
				hwrst_q <= pwdata[CTRL_HWRST_BIT];
		end
	end

	// Sequencer; sequences run whole, and only a reset can break one midway
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= S_IDLE;
			cmd_q <= CMD_READ;
			idx_q <= 3'h0;
			nopoll_q <= 1'b0;
			exp_q <= 1'b1;
			rechk_q <= 1'b0;
			rdata_q <= 8'h00;
			eng_start_q <= 1'b0;
			eng_rd_q <= 1'b0;
			eng_addr_q <= '0;
			eng_data_q <= 8'h00;
		end
		else
		begin
			eng_start_q <= 1'b0;
			case (state_q)
				S_IDLE:
					if (go_wr && go_ok)
					begin
						cmd_q <= go_cmd;
						nopoll_q <= pwdata[CTRL_NOPOLL_BIT];
						idx_q <= 3'h0;
						rechk_q <= 1'b0;
						// program expects true bit 7; erase and suspend expect one
						exp_q <= (go_cmd inside {CMD_PROGRAM, CMD_BYP_PROGRAM}) ?
							wdata_q[POLL_BIT] : 1'b1;
						state_q <= (go_cmd == CMD_POLL) ? S_POLL : S_ISSUE;
					end
				S_ISSUE:
				begin
					eng_start_q <= 1'b1;
					eng_rd_q <= step.rd;
					eng_addr_q <= step.addr;
					eng_data_q <= step.data;
					state_q <= S_WAIT;
				end
				S_WAIT:
					if (eng_done)
					begin
						idx_q <= idx_q + 3'h1;
						if (!step.last)
							state_q <= S_ISSUE;
						// polling starts after the final rising strobe
						else if (poll_cmd && !nopoll_q)
							state_q <= S_POLL;
						else
							state_q <= S_IDLE;
						if (step.last && step.rd)
							rdata_q <= eng_rdata;
					end
				S_POLL, S_FINAL:
				begin
					// poll at the target or sector address
					eng_start_q <= 1'b1;
					eng_rd_q <= 1'b1;
					eng_addr_q <= addr_q;
					state_q <= (state_q == S_POLL) ? S_PWAIT : S_FWAIT;
				end
				S_PWAIT:
					if (eng_done)
					begin
						if (poll_match)
							state_q <= S_FINAL;
						else if (rechk_q)
							state_q <= S_ABORT;
						else
							state_q <= S_POLL;
						// Bit 7 may turn true together with the failure bit
						if (eng_rdata[FAIL_BIT])
							rechk_q <= 1'b1;
					end
				S_FWAIT:
					if (eng_done)
					begin
						// data taken from the read after the match
						rdata_q <= eng_rdata;
						state_q <= S_IDLE;
					end
				S_ABORT:
				begin
					eng_start_q <= 1'b1;
					eng_rd_q <= 1'b0;
					eng_addr_q <= addr_q;
					eng_data_q <= D_RESET;
					state_q <= S_AWAIT;
				end
				S_AWAIT:
					if (eng_done)
						state_q <= S_IDLE;
				default:
					state_q <= S_IDLE;
			endcase
		end
	end

	// Status and mode tracking; a set meets its clear only under hardware reset, which wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_q <= 1'b0;
			fail_q <= 1'b0;
			refused_q <= 1'b0;
			bypass_q <= 1'b0;
			suspended_q <= 1'b0;
			autosel_q <= 1'b0;
			erasing_q <= 1'b0;
		end
		else if (hwrst_q)
		begin
			bypass_q <= 1'b0;
			suspended_q <= 1'b0;
			autosel_q <= 1'b0;
			erasing_q <= 1'b0;
			refused_q <= refused_q || go_wr;
		end
		else
		begin
			if (go_wr)
			begin
				done_q <= done_q && !go_ok;
				fail_q <= fail_q && !go_ok;
				refused_q <= !go_ok;
			end
			if (finish_ok || finish_fail)
				done_q <= 1'b1;
			if (finish_fail)
			begin
				fail_q <= 1'b1;
				autosel_q <= 1'b0;
				erasing_q <= 1'b0;
			end
			if (finish_ok)
				case (cmd_q)
					CMD_RESET: autosel_q <= 1'b0;
					CMD_AUTOSEL: autosel_q <= 1'b1;
					CMD_BYP_ENTER: bypass_q <= 1'b1;
					CMD_BYP_EXIT: bypass_q <= 1'b0;
					CMD_SECTOR_ERASE, CMD_SECTOR_ADD: erasing_q <= nopoll_q;
					CMD_POLL: erasing_q <= 1'b0;
					CMD_SUSPEND: suspended_q <= 1'b1;
					CMD_RESUME: suspended_q <= 1'b0;
					default: autosel_q <= autosel_q;
				endcase
		end
	end

	// addition window restarts on each sector write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			win_q <= 32'h0;
		else if (seq_end && cmd_q inside {CMD_SECTOR_ERASE, CMD_SECTOR_ADD})
			win_q <= 32'(ERASE_WIN_CYCLES);
		else if (win_open)
			win_q <= win_q - 32'h1;
	end

	// strobe-edge latching depends on the engine's setup and hold
	fcp_bus_cycle u_cycle (
		.pclk(pclk),
		.presetn(presetn),
		.start(eng_start_q),
		.rd(eng_rd_q),
		.addr(eng_addr_q),
		.wdata(eng_data_q),
		.done(eng_done),
		.rdata(eng_rdata),
		.flash_addr(flash_addr),
		.flash_dq_o(flash_dq_o),
		.flash_dq_oe_n(flash_dq_oe_n),
		.flash_dq_i(flash_dq_i),
		.flash_ce_n(flash_ce_n),
		.flash_oe_n(flash_oe_n),
		.flash_we_n(flash_we_n)
	);
endmodule : fcp_host

// ### sim/fcp_host_properties.sv
// Port checker of the flash command host, bound into the design
module fcp_host_properties
	import fcp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [fcp_pkg::FA_W-1:0] flash_addr,
	input wire logic [7:0] flash_dq_o,
	input wire logic flash_dq_oe_n,
	input wire logic [7:0] flash_dq_i,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic flash_reset_n
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_we_low;
		!flash_we_n [*8];
	endsequence
	sequence s_wr_hold;
		(!flash_ce_n && !flash_dq_oe_n) [*8];
	endsequence
	AST_PREADY_NEXT: assert property (s_setup |=> pready)
		else $error("pready missing in access cycle");
	AST_PREADY_ONE: assert property (pready |=> !pready)
		else $error("pready held too long");
	AST_SLVERR_MAP: assert property (pready |-> pslverr == (paddr > REG_STATUS || paddr[1:0] != 2'b00))
		else $error("pslverr disagrees with the map");
	AST_WR_CYCLE: assert property (!flash_we_n |-> !flash_ce_n && !flash_dq_oe_n && flash_oe_n)
		else $error("write strobe outside a driven cycle");
	AST_RD_CYCLE: assert property (!flash_oe_n |-> !flash_ce_n && flash_dq_oe_n && flash_we_n)
		else $error("read strobe while driving data");
	AST_LATCH_STABLE: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_addr) && $stable(flash_dq_o))
		else $error("address or data moved under the write strobe");
	AST_WE_WIDTH: assert property ($fell(flash_we_n) |=> s_we_low)
		else $error("write strobe too short");
	AST_WE_SETUP: assert property ($fell(flash_we_n) |-> !$past(flash_ce_n, 2))
		else $error("write strobe without address setup");
	AST_WE_HOLD: assert property ($rose(flash_we_n) |-> s_wr_hold)
		else $error("data released too soon after the write strobe");
	AST_OE_WIDTH: assert property ($fell(flash_oe_n) |=> !flash_oe_n [*8])
		else $error("read strobe too short");
	COV_WRITE: cover property ($rose(flash_we_n));
endmodule : fcp_host_properties

bind fcp_host fcp_host_properties chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .flash_addr, .flash_dq_o, .flash_dq_oe_n,
	.flash_dq_i, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n);

// ### sim/fcp_flash_model.sv
// Behavioural byte-wide flash answering the host's pin cycles
module fcp_flash_model
#(
	// Arbitrary identity values
	parameter logic [7:0] MAKER_CODE = 8'h3c,
	parameter logic [7:0] DEVICE_CODE = 8'h5a
)
(
	input wire logic [16:0] flash_addr,
	input wire logic [7:0] flash_dq_o,
	input wire logic flash_ce_n,
	input wire logic flash_oe_n,
	input wire logic flash_we_n,
	input wire logic flash_reset_n,
	output logic [7:0] flash_dq_i
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] mem [0:255];
	logic [24:0] log [$];
	logic [16:0] a_lat;
	logic [7:0] pv, rd_v;
	logic [7:0] last_v = 8'h00;
	logic [4:0] esec;
	int cyc, polln;
	bit autosel, prog, byp, pe, susp;
	initial
		foreach (mem[i]) mem[i] = 8'h00;
	always @(negedge flash_we_n)
		a_lat = flash_addr;
	always @(posedge flash_we_n)
		if (!flash_ce_n && flash_reset_n)
			decode(a_lat, flash_dq_o);
	task automatic decode(input logic [16:0] a, input logic [7:0] d);
		int k;
		k = cyc;
		cyc = 0;
		log.push_back({a, d});
		if (prog)
		begin
			mem[a[7:0]] = d;
			pv = d;
			polln = 3;
			pe = 1;
			prog = 0;
		end
		else if (d == 8'hf0)
			autosel = 0;
		else if (byp)
		begin
			prog = d == 8'ha0;
			cyc = d == 8'h90 ? 9 : 0;
			byp = !(k == 9 && d == 8'h00);
		end
		else if (d == 8'hb0 && polln > 0 && !pe)
		begin
			susp = 1;
			polln = 0;
		end
		else if (d == 8'h30 && susp)
		begin
			susp = 0;
			pe = 0;
			polln = 3;
		end
		else if (a[10:0] == 11'h555 && d == 8'haa && (k == 0 || k == 3))
			cyc = k + 1;
		else if (a[10:0] == 11'h2aa && d == 8'h55 && (k == 1 || k == 4))
			cyc = k + 1;
		else if (k == 2 && a[10:0] == 11'h555)
		begin
			autosel = d == 8'h90;
			prog = d == 8'ha0;
			byp = d == 8'h20;
			cyc = d == 8'h80 ? 3 : 0;
		end
		else if (k == 5 && (d == 8'h30 || d == 8'h10 && a[10:0] == 11'h555))
		begin
			pe = 0;
			polln = 3;
			esec = a[16:12];
			foreach (mem[i]) mem[i] = 8'hff;
		end
	endtask : decode
	always_comb
		if (autosel)
			rd_v = flash_addr[1:0] == 2'h0 ? MAKER_CODE : flash_addr[1:0] == 2'h1 ? DEVICE_CODE : 8'h00;
		else if (polln > 0)
			// Timing-limit bit stays low while busy
			rd_v = {pe ? ~pv[7] : 1'b0, pv[6], 1'b0, pv[4:0]};
		else if (susp && flash_addr[16:12] == esec)
			rd_v = 8'h80;
		else
			rd_v = mem[flash_addr[7:0]];
	// Released bus shows the inverse so a stale value never matches
	assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? rd_v : ~last_v;
	always @(posedge flash_oe_n)
		if (!flash_ce_n)
		begin
			last_v = rd_v;
			polln = polln > 0 ? polln - 1 : 0;
		end
	always @(negedge flash_reset_n)
	begin
		{autosel, prog, byp, pe, susp} = 5'h00;
		cyc = 0;
		polln = 0;
	end
endmodule : fcp_flash_model

// ### sim/test_fcp_host.sv
// Self-checking bench of the flash command host against a flash model
module test_fcp_host;
	timeunit 1ns;
	timeprecision 100ps;
	import fcp_pkg::*;
	// Arbitrary identity values, matching the flash model
	localparam logic [7:0] MAKER = 8'h3c;
	localparam logic [7:0] DEVICE = 8'h5a;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, st;
	logic pready, pslverr, err, flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n, flash_reset_n;
	logic [16:0] flash_addr, a, a2;
	logic [7:0] flash_dq_o, flash_dq_i, d;
	logic [7:0] idv [3] = '{MAKER, DEVICE, 8'h00};
	fcp_cmd_e bad [4] = '{CMD_BYP_PROGRAM, CMD_SUSPEND, CMD_RESUME, CMD_SECTOR_ADD};
	logic [24:0] exp_q [$];
	logic [15:0] lfsr = 16'h0028;
	int n_errors = 0;
	int total_checks = 0;
	always #2 pclk = ~pclk;
	fcp_host #(.ERASE_WIN_CYCLES(50)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .flash_addr, .flash_dq_o, .flash_dq_oe_n,
		.flash_dq_i, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n);
	fcp_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) fm (.flash_addr, .flash_dq_o,
		.flash_ce_n, .flash_oe_n, .flash_we_n, .flash_reset_n, .flash_dq_i);
	function automatic logic [15:0] next_rand(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : next_rand
	task automatic test_done();
		if (n_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		st = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			n_errors++;
			test_done();
		end
		@(posedge pclk);
	endtask : apb
	task automatic wr(input logic [16:0] ea, input logic [7:0] ed);
		exp_q.push_back({ea, ed});
	endtask : wr
	// Two unlock writes, then one command write
	task automatic unlock(input logic [7:0] c, input logic [16:0] ca);
		wr(17'h00555, 8'haa);
		wr(17'h002aa, 8'h55);
		wr(ca, c);
	endtask : unlock
	task automatic cmd(input fcp_cmd_e c, input logic np, input logic [16:0] ad,
		input logic [7:0] wd);
		int n;
		n = 0;
		apb(1'b1, REG_ADDR, 32'(ad));
		apb(1'b1, REG_WDATA, 32'(wd));
		apb(1'b1, REG_CTRL, {23'h0, 1'b1, 3'h0, np, 4'(c)});
		do
		begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end
		while (st[ST_DONE] !== 1'b1 && st[ST_REFUSED] !== 1'b1 && n < 400);
		if (n >= 400)
		begin
			n_errors++;
			test_done();
		end
		chk("write count", 32'(fm.log.size()), 32'(exp_q.size()));
		foreach (exp_q[i])
			chk("write cycle", 32'(fm.log[i]), 32'(exp_q[i]));
		exp_q.delete();
		fm.log.delete();
	endtask : cmd
	task automatic ok(input logic [7:0] rd);
		chk("rdata done fail", 32'({st[23:16], st[ST_FAIL], st[ST_DONE]}), 32'({rd, 2'b01}));
	endtask : ok
	task automatic rnd();
		lfsr = next_rand(lfsr);
		a = {1'b0, lfsr};
		d = lfsr[15:8];
	endtask : rnd
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl reset", st, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk("unmapped", {st[30:0], err}, 32'h1);
		rnd();
		apb(1'b1, REG_ADDR, 32'(a));
		apb(1'b0, REG_ADDR, 32'h0);
		chk("addr reg", st, 32'(a));
		for (int i = 0; i < 3; i++)
		begin
			unlock(8'h90, 17'h00555);
			cmd(CMD_AUTOSEL, 1'b0, {5'h1f, 10'h0, 2'(i)}, 8'h00);
			chk("id", 32'({st[ST_AUTOSEL], st[23:16]}), 32'({1'b1, idv[i]}));
		end
		wr(a, 8'hf0);
		cmd(CMD_RESET, 1'b0, a, 8'h00);
		chk("autosel off", 32'(st[ST_AUTOSEL]), 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			rnd();
			unlock(8'ha0, 17'h00555);
			wr(a, d);
			cmd(CMD_PROGRAM, 1'b0, a, d);
			ok(d);
			cmd(CMD_READ, 1'b0, a, 8'h00);
			ok(d);
		end
		unlock(8'h20, 17'h00555);
		cmd(CMD_BYP_ENTER, 1'b0, a, 8'h00);
		chk("bypass on", 32'(st[ST_BYPASS]), 32'h1);
		cmd(CMD_CHIP_ERASE, 1'b0, a, 8'h00);
		chk("refused", 32'(st[ST_REFUSED]), 32'h1);
		rnd();
		wr(a, 8'ha0);
		wr(a, d);
		cmd(CMD_BYP_PROGRAM, 1'b0, a, d);
		ok(d);
		wr(a, 8'h90);
		wr(a, 8'h00);
		cmd(CMD_BYP_EXIT, 1'b0, a, 8'h00);
		chk("bypass off", 32'(st[ST_BYPASS]), 32'h0);
		unlock(8'h80, 17'h00555);
		unlock(8'h10, 17'h00555);
		cmd(CMD_CHIP_ERASE, 1'b0, a, 8'h00);
		ok(8'hff);
		unlock(8'h80, 17'h00555);
		unlock(8'h30, a);
		cmd(CMD_SECTOR_ERASE, 1'b1, a, 8'h00);
		wr(a, 8'h30);
		cmd(CMD_SECTOR_ADD, 1'b1, a, 8'h00);
		chk("window", 32'(st[ST_WINDOW]), 32'h1);
		wr(a, 8'hb0);
		cmd(CMD_SUSPEND, 1'b0, a, 8'h00);
		ok(8'h80);
		chk("suspended", 32'(st[ST_SUSPENDED]), 32'h1);
		a2 = a ^ 17'h10001;
		unlock(8'ha0, 17'h00555);
		wr(a2, d);
		cmd(CMD_PROGRAM, 1'b0, a2, d);
		ok(d);
		wr(a, 8'h30);
		cmd(CMD_RESUME, 1'b0, a, 8'h00);
		chk("resumed", 32'(st[ST_SUSPENDED]), 32'h0);
		cmd(CMD_POLL, 1'b0, a, 8'h00);
		ok(8'hff);
		foreach (bad[i])
		begin
			cmd(bad[i], 1'b0, a, 8'h00);
			chk("refused", 32'(st[ST_REFUSED]), 32'h1);
		end
		apb(1'b1, REG_CTRL, 32'h200);
		apb(1'b0, REG_CTRL, 32'h0);
		chk("hw reset", {st[30:0], flash_reset_n}, {21'h0, 1'b1, 5'h00, 4'(CMD_POLL), 1'b0});
		apb(1'b1, REG_CTRL, 32'h0);
		test_done();
	end
endmodule : test_fcp_host
